//--- rtl/gpb_defines.vh
/*
 * Constants of the GPIO port bank: register indices, field positions,
 * implemented-bit masks, reset values and option encodings.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef GPB_DEFINES_VH
`define GPB_DEFINES_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define GPB_IDX_P0_DIR   12'h0b8
`define GPB_IDX_P1_DIR   12'h0c1
`define GPB_IDX_P5_DIR   12'h0c5
`define GPB_IDX_P0_DATA  12'h0d0
`define GPB_IDX_P1_DATA  12'h0d1
`define GPB_IDX_P5_DATA  12'h0d5
`define GPB_IDX_P0_PULL  12'h0e0
`define GPB_IDX_P5_PULL  12'h0e5
`define GPB_IDX_P1_PULL  12'he10
`define GPB_IDX_CTRL     12'h0f0
`define GPB_IDX_STAT     12'h0f1
`define GPB_IDX_DIR_SET  12'h0f8
`define GPB_IDX_DIR_CLR  12'h0f9

// ****************************************************************
// Implemented bits and reset values
// ****************************************************************
`define GPB_P0_PIN_MASK  8'hff
`define GPB_P0_CTL_MASK  8'hfb
`define GPB_P1_MASK      8'hff
`define GPB_P5_MASK      8'h11
`define GPB_RESET_BYTE   8'h00

// ****************************************************************
// Control register fields
// ****************************************************************
`define GPB_CTRL_EXT_EN  0
`define GPB_CTRL_EDGE_LO 1
`define GPB_CTRL_EDGE_HI 2
`define GPB_CTRL_IR_EN   3
`define GPB_CTRL_RST_OPT 4
`define GPB_CTRL_CLK_LO  5
`define GPB_CTRL_CLK_HI  6
`define GPB_CTRL_MASK    8'h7f
`define GPB_STAT_FLAG    0

// ****************************************************************
// Option encodings
// ****************************************************************
`define GPB_EDGE_RISE    2'h1
`define GPB_EDGE_FALL    2'h2
`define GPB_EDGE_BOTH    2'h3
`define GPB_CLK_NONE     2'h0
`define GPB_CLK_RC       2'h1
`define GPB_CLK_XTAL     2'h2

// ****************************************************************
// Port select codes for the set and clear aliases
// ****************************************************************
`define GPB_SEL_P0       2'h0
`define GPB_SEL_P1       2'h1
`define GPB_SEL_P5       2'h2

`endif

//--- rtl/gpb_pin_ctrl.v
/*
 * Per-port pin driver: turns direction, latch and pull-up bits plus
 * alternate-function overrides into registered pin controls.
 * Assumes all inputs come from logic on sys_clk.
 */
`timescale 1ns/1ps

module gpb_pin_ctrl (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst,
  // Port settings
  input  wire [7:0] dirBits,
  input  wire [7:0] latchBits,
  input  wire [7:0] pullBits,
  input  wire [7:0] implMask,
  // Alternate-function overrides
  input  wire [7:0] forceIn,
  input  wire [7:0] noPull,
  input  wire [7:0] forceOut,
  input  wire [7:0] forceVal,
  // Pin controls
  output reg  [7:0] pinOut,
  output reg  [7:0] pinOe,
  output reg  [7:0] pullOn
);

  reg [7:0] oeNext;

  always @* begin
    oeNext = implMask & ~forceIn & (dirBits | forceOut);
  end

  // Registered pin controls
  always @(posedge sys_clk) begin
    if (rst) begin
      pinOut <= 8'h00;
      pinOe  <= 8'h00;
      pullOn <= 8'h00;
    end else begin
      pinOut <= ((forceOut & forceVal) | (~forceOut & latchBits)) & oeNext;
      pinOe  <= oeNext;
      pullOn <= implMask & pullBits & ~oeNext & ~noPull;
    end
  end

endmodule // gpb_pin_ctrl

//--- rtl/gpb_sync.v
/*
 * Two-stage synchroniser for a group of pin levels.
 * Assumes inputs are asynchronous to sys_clk; only the second stage is used.
 */
`timescale 1ns/1ps

module gpb_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             sys_clk,
  input  wire             rst,
  // Levels
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_reg;

  // Two flip-flops, first stage read only by the second
  always @(posedge sys_clk) begin
    if (rst) begin
      stage1_reg <= {WIDTH{1'b0}};
      syncOut    <= {WIDTH{1'b0}};
    end else begin
      stage1_reg <= asyncIn;
      syncOut    <= stage1_reg;
    end
  end

endmodule // gpb_sync

//--- rtl/gpb_top.v
/*
 * GPIO port bank: ports 0, 1 and 5 with direction, data and write-only
 * pull-up registers, shared-pin switching and the external interrupt
 * edge flag, reached over an AHB-Lite slave port.
 * Assumes one sys_clk domain, a synchronous active-high reset, pins that
 * are asynchronous, and an IR carrier from logic on sys_clk.
 */
`timescale 1ns/1ps
`include "gpb_defines.vh"

module gpb_top (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rst,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Port 0 pins
  input  wire [7:0]  port0In,
  output wire [7:0]  port0Out,
  output wire [7:0]  port0Oe,
  output wire [7:0]  port0PullOn,
  // Port 1 pins
  input  wire [7:0]  port1In,
  output wire [7:0]  port1Out,
  output wire [7:0]  port1Oe,
  output wire [7:0]  port1PullOn,
  // Port 5 pins
  input  wire [7:0]  port5In,
  output wire [7:0]  port5Out,
  output wire [7:0]  port5Oe,
  output wire [7:0]  port5PullOn,
  // Shared functions
  input  wire        irCarrierIn,
  output reg         extIntFlag,
  output reg         extIntRequest
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg  [7:0]  p0Dir_reg,  p1Dir_reg,  p5Dir_reg;
  reg  [7:0]  p0Dir_next, p1Dir_next, p5Dir_next;
  reg  [7:0]  p0Lat_reg,  p1Lat_reg,  p5Lat_reg;
  reg  [7:0]  p0Lat_next, p1Lat_next, p5Lat_next;
  reg  [7:0]  p0Pull_reg, p1Pull_reg, p5Pull_reg;
  reg  [7:0]  p0Pull_next, p1Pull_next, p5Pull_next;
  reg  [7:0]  ctrl_reg;
  reg  [7:0]  ctrl_next;
  reg         flag_next;
  reg         wrPend_reg;
  reg  [11:0] wrIdx_reg;
  reg         p00Prev_reg;
  reg  [31:0] rdNext;
  reg  [7:0]  p0Read;
  reg  [7:0]  p0ForceIn;
  reg  [7:0]  p0NoPull;
  reg  [7:0]  p5ForceOut;
  reg  [7:0]  p5ForceVal;
  reg         edgeHit;
  wire [7:0]  p0Sync, p1Sync, p5Sync;
  wire        addrPhase;
  wire        addrOk;
  wire [11:0] rdIdx;
  wire [7:0]  wByte;
  wire [1:0]  edgeSel;
  wire [1:0]  clkOpt;
  wire        p00Now;

  assign addrPhase = hsel & hready & htrans[1];
  assign addrOk    = (haddr[31:14] == 18'h00000) & (haddr[1:0] == 2'h0);
  assign rdIdx     = addrOk ? haddr[13:2] : 12'hfff;
  assign wByte     = hwdata[7:0];
  assign edgeSel   = ctrl_reg[`GPB_CTRL_EDGE_HI:`GPB_CTRL_EDGE_LO];
  assign clkOpt    = ctrl_reg[`GPB_CTRL_CLK_HI:`GPB_CTRL_CLK_LO];
  assign p00Now    = p0Sync[0];

  // ****************************************************************
  // Pin input synchronisers
  // ****************************************************************
  gpb_sync #(.WIDTH(8)) u_sync0 (
    .sys_clk (sys_clk),
    .rst     (rst),
    .asyncIn (port0In),
    .syncOut (p0Sync)
  );

  gpb_sync #(.WIDTH(8)) u_sync1 (
    .sys_clk (sys_clk),
    .rst     (rst),
    .asyncIn (port1In),
    .syncOut (p1Sync)
  );

  gpb_sync #(.WIDTH(8)) u_sync5 (
    .sys_clk (sys_clk),
    .rst     (rst),
    .asyncIn (port5In & `GPB_P5_MASK),
    .syncOut (p5Sync)
  );

  // ****************************************************************
  // Register write path
  // ****************************************************************
  // Next values of every software register
  always @* begin
    p0Dir_next  = p0Dir_reg;
    p1Dir_next  = p1Dir_reg;
    p5Dir_next  = p5Dir_reg;
    p0Lat_next  = p0Lat_reg;
    p1Lat_next  = p1Lat_reg;
    p5Lat_next  = p5Lat_reg;
    p0Pull_next = p0Pull_reg;
    p1Pull_next = p1Pull_reg;
    p5Pull_next = p5Pull_reg;
    ctrl_next   = ctrl_reg;
    flag_next   = extIntFlag;
    if (wrPend_reg) begin
      case (wrIdx_reg)
        // bit 2 direction held at zero
        `GPB_IDX_P0_DIR:  p0Dir_next  = wByte & `GPB_P0_CTL_MASK;
        `GPB_IDX_P1_DIR:  p1Dir_next  = wByte & `GPB_P1_MASK;
        `GPB_IDX_P5_DIR:  p5Dir_next  = wByte & `GPB_P5_MASK;
        `GPB_IDX_P0_DATA: p0Lat_next  = wByte & `GPB_P0_CTL_MASK;
        `GPB_IDX_P1_DATA: p1Lat_next  = wByte & `GPB_P1_MASK;
        `GPB_IDX_P5_DATA: p5Lat_next  = wByte & `GPB_P5_MASK;
        `GPB_IDX_P0_PULL: p0Pull_next = wByte & `GPB_P0_CTL_MASK;
        `GPB_IDX_P1_PULL: p1Pull_next = wByte & `GPB_P1_MASK;
        `GPB_IDX_P5_PULL: p5Pull_next = wByte & `GPB_P5_MASK;
        `GPB_IDX_CTRL:    ctrl_next   = wByte & `GPB_CTRL_MASK;
        `GPB_IDX_STAT: begin
          if (hwdata[`GPB_STAT_FLAG]) begin
            flag_next = 1'b0;
          end
        end
        `GPB_IDX_DIR_SET: begin
          case (hwdata[9:8])
            `GPB_SEL_P0: p0Dir_next = p0Dir_reg | (wByte & `GPB_P0_CTL_MASK);
            `GPB_SEL_P1: p1Dir_next = p1Dir_reg | (wByte & `GPB_P1_MASK);
            `GPB_SEL_P5: p5Dir_next = p5Dir_reg | (wByte & `GPB_P5_MASK);
            default:     p0Dir_next = p0Dir_reg;
          endcase
        end
        `GPB_IDX_DIR_CLR: begin
          case (hwdata[9:8])
            `GPB_SEL_P0: p0Dir_next = p0Dir_reg & ~wByte;
            `GPB_SEL_P1: p1Dir_next = p1Dir_reg & ~wByte;
            `GPB_SEL_P5: p5Dir_next = p5Dir_reg & ~wByte;
            default:     p0Dir_next = p0Dir_reg;
          endcase
        end
        default: ctrl_next = ctrl_reg;
      endcase
    end
    if (edgeHit) begin
      flag_next = 1'b1;
    end
  end

  // Edge detector on the synchronised external interrupt pin
  always @* begin
    case (edgeSel)
      `GPB_EDGE_RISE: edgeHit = p00Now & ~p00Prev_reg;
      `GPB_EDGE_FALL: edgeHit = ~p00Now & p00Prev_reg;
      `GPB_EDGE_BOTH: edgeHit = p00Now ^ p00Prev_reg;
      default:        edgeHit = 1'b0;
    endcase
  end

  // ****************************************************************
  // Shared-pin switching
  // ****************************************************************
  // alternate roles of shared pins
  always @* begin
    p0ForceIn  = 8'h04;
    p0NoPull   = 8'h04;
    p5ForceOut = 8'h00;
    p5ForceVal = 8'h00;
    if (ctrl_reg[`GPB_CTRL_EXT_EN]) begin
      p0ForceIn[0] = 1'b1;
    end
    if (clkOpt == `GPB_CLK_RC || clkOpt == `GPB_CLK_XTAL) begin
      p0ForceIn[3] = 1'b1;
      p0NoPull[3]  = 1'b1;
    end
    if (clkOpt == `GPB_CLK_XTAL) begin
      p0ForceIn[4] = 1'b1;
      p0NoPull[4]  = 1'b1;
    end
    if (ctrl_reg[`GPB_CTRL_IR_EN]) begin
      p5ForceOut[4] = 1'b1;
      p5ForceVal[4] = irCarrierIn;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // port 0 read value
  always @* begin
    p0Read    = (p0Sync & ~p0Dir_next) | (p0Lat_next & p0Dir_next);
    p0Read[2] = ctrl_next[`GPB_CTRL_RST_OPT] ? 1'b1 : p0Sync[2];
  end

  // Read mux built on next values so a write is seen at once
  always @* begin
    rdNext = 32'h00000000;
    case (rdIdx)
      `GPB_IDX_P0_DIR:  rdNext[7:0] = p0Dir_next;
      `GPB_IDX_P1_DIR:  rdNext[7:0] = p1Dir_next;
      `GPB_IDX_P5_DIR:  rdNext[7:0] = p5Dir_next;
      `GPB_IDX_P0_DATA: rdNext[7:0] = p0Read;
      `GPB_IDX_P1_DATA: rdNext[7:0] = (p1Sync & ~p1Dir_next) | (p1Lat_next & p1Dir_next);
      `GPB_IDX_P5_DATA: rdNext[7:0] = ((p5Sync & ~p5Dir_next) | (p5Lat_next & p5Dir_next))
                                      & `GPB_P5_MASK;
      `GPB_IDX_CTRL:    rdNext[7:0] = ctrl_next;
      `GPB_IDX_STAT:    rdNext[`GPB_STAT_FLAG] = flag_next;
      default:          rdNext = 32'h00000000;
    endcase
  end

  // ****************************************************************
  // Bus and register state
  // ****************************************************************
  always @(posedge sys_clk) begin
    if (rst) begin
      p0Dir_reg     <= `GPB_RESET_BYTE;
      p1Dir_reg     <= `GPB_RESET_BYTE;
      p5Dir_reg     <= `GPB_RESET_BYTE;
      p0Lat_reg     <= `GPB_RESET_BYTE;
      p1Lat_reg     <= `GPB_RESET_BYTE;
      p5Lat_reg     <= `GPB_RESET_BYTE;
      p0Pull_reg    <= `GPB_RESET_BYTE;
      p1Pull_reg    <= `GPB_RESET_BYTE;
      p5Pull_reg    <= `GPB_RESET_BYTE;
      ctrl_reg      <= `GPB_RESET_BYTE;
      extIntFlag    <= 1'b0;
      extIntRequest <= 1'b0;
      p00Prev_reg   <= 1'b0;
      wrPend_reg    <= 1'b0;
      wrIdx_reg     <= 12'h000;
      hrdata        <= 32'h00000000;
      hreadyout     <= 1'b0;
      hresp         <= 1'b0;
    end else begin
      p0Dir_reg     <= p0Dir_next;
      p1Dir_reg     <= p1Dir_next;
      p5Dir_reg     <= p5Dir_next;
      p0Lat_reg     <= p0Lat_next;
      p1Lat_reg     <= p1Lat_next;
      p5Lat_reg     <= p5Lat_next;
      p0Pull_reg    <= p0Pull_next;
      p1Pull_reg    <= p1Pull_next;
      p5Pull_reg    <= p5Pull_next;
      ctrl_reg      <= ctrl_next;
      extIntFlag    <= flag_next;
      // Request raised only when enabled
      extIntRequest <= flag_next & ctrl_next[`GPB_CTRL_EXT_EN];
      p00Prev_reg   <= p00Now;
      wrPend_reg    <= addrPhase & hwrite;
      wrIdx_reg     <= rdIdx;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
      if (addrPhase & ~hwrite) begin
        hrdata <= rdNext;
      end
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  // three port drivers
  gpb_pin_ctrl u_pin0 (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .dirBits   (p0Dir_reg),
    .latchBits (p0Lat_reg),
    .pullBits  (p0Pull_reg),
    .implMask  (`GPB_P0_PIN_MASK),
    .forceIn   (p0ForceIn),
    .noPull    (p0NoPull),
    .forceOut  (8'h00),
    .forceVal  (8'h00),
    .pinOut    (port0Out),
    .pinOe     (port0Oe),
    .pullOn    (port0PullOn)
  );

  gpb_pin_ctrl u_pin1 (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .dirBits   (p1Dir_reg),
    .latchBits (p1Lat_reg),
    .pullBits  (p1Pull_reg),
    .implMask  (`GPB_P1_MASK),
    .forceIn   (8'h00),
    .noPull    (8'h00),
    .forceOut  (8'h00),
    .forceVal  (8'h00),
    .pinOut    (port1Out),
    .pinOe     (port1Oe),
    .pullOn    (port1PullOn)
  );

  gpb_pin_ctrl u_pin5 (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .dirBits   (p5Dir_reg),
    .latchBits (p5Lat_reg),
    .pullBits  (p5Pull_reg),
    .implMask  (`GPB_P5_MASK),
    .forceIn   (8'h00),
    .noPull    (8'h00),
    .forceOut  (p5ForceOut),
    .forceVal  (p5ForceVal),
    .pinOut    (port5Out),
    .pinOe     (port5Oe),
    .pullOn    (port5PullOn)
  );

endmodule // gpb_top

//--- verification/gpb_board_model.sv
/* Board model for one 8-bit port: resolves each pin level.
   Assumes the device drives, then the board, then the pull-up. */
`timescale 1ns/1ps

module gpb_board_model (
  // Clock
  input  wire        sys_clk,
  // Device side
  input  wire [7:0]  pinOut,
  input  wire [7:0]  pinOe,
  input  wire [7:0]  pinPull,
  // Board side
  input  wire [7:0]  boardEn,
  input  wire [7:0]  boardVal,
  output logic [7:0] pinLevel
);
  logic [7:0] floatVal = 8'h00;

  // Floating pins wander every cycle
  always @(posedge sys_clk) begin
    floatVal <= ~floatVal;
  end

  // Pin level resolution
  always_comb begin
    pinLevel = (pinOe & pinOut) | (~pinOe & boardEn & boardVal)
      | (~pinOe & ~boardEn & pinPull) | (~pinOe & ~boardEn & ~pinPull & floatVal);
  end
endmodule // gpb_board_model

//--- verification/gpb_top_asserts.sv
/* Port checker for gpb_top.
   Assumes it is bound onto gpb_top and sees only its ports. */
`timescale 1ns/1ps

module gpb_top_asserts (
  // Clock and reset
  input wire        sys_clk,
  input wire        rst,
  // Bus
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  // Pins
  input wire [7:0]  port0Oe,
  input wire [7:0]  port0PullOn,
  input wire [7:0]  port1Out,
  input wire [7:0]  port1Oe,
  input wire [7:0]  port1PullOn,
  input wire [7:0]  port5Oe,
  input wire [7:0]  port5PullOn,
  input wire        extIntFlag,
  input wire        extIntRequest
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Bus steps
  sequence rdTaken;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence p1DirTaken;
    hsel && hready && htrans[1] && hwrite && haddr == 32'h0000_0304;
  endsequence

  zero_wait_a: assert property (!$past(rst) |-> hreadyout)
    else $error("wait state inserted");
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  read_upper_zero_a: assert property (rdTaken |=> hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  dir_to_oe_a: assert property (p1DirTaken ##2 1'b1 |=> port1Oe == $past(hwdata[7:0], 2))
    else $error("direction not on drive enables");
  p02_no_drive_a: assert property (port0Oe[2] == 1'b0)
    else $error("input-only pin driven");
  p02_no_pull_a: assert property (port0PullOn[2] == 1'b0)
    else $error("input-only pin pulled");
  pull_input_only_a: assert property (((port0PullOn & port0Oe) | (port1PullOn & port1Oe)
    | (port5PullOn & port5Oe)) == 8'h00) else $error("pull-up on driven pin");
  p5_absent_bits_a: assert property (((port5Oe | port5PullOn) & 8'hee) == 8'h00)
    else $error("absent port5 bit active");
  out_needs_oe_a: assert property ((port1Out & ~port1Oe) == 8'h00)
    else $error("drive value on input pin");
  request_needs_flag_a: assert property (extIntRequest |-> extIntFlag)
    else $error("request without flag");
endmodule // gpb_top_asserts

bind gpb_top gpb_top_asserts i_gpb_top_asserts (
  .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .port0Oe(port0Oe), .port0PullOn(port0PullOn),
  .port1Out(port1Out), .port1Oe(port1Oe), .port1PullOn(port1PullOn), .port5Oe(port5Oe),
  .port5PullOn(port5PullOn), .extIntFlag(extIntFlag), .extIntRequest(extIntRequest));

//--- verification/gpb_top_tb.sv
/* Self-checking bench for gpb_top with three board models.
   Assumes the checker is bound in and AHB-Lite zero-wait answers. */
`timescale 1ns/1ps

module gpb_top_tb;
  logic        sys_clk = 0, rst = 1, hsel = 0, hwrite = 0, irCarrierIn = 0;
  logic [31:0] haddr = 0, hwdata = 0, rnd = 78, rdv;
  logic [1:0]  htrans = 0;
  logic [7:0]  b0En = 8'hff, b0Val = 0, b1En = 8'hff, b1Val = 0, b5En = 8'hff, b5Val = 0;
  logic [7:0]  d, v;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, extIntFlag, extIntRequest;
  wire  [7:0]  p0In, p0Out, p0Oe, p0Pull, p1In, p1Out, p1Oe, p1Pull;
  wire  [7:0]  p5In, p5Out, p5Oe, p5Pull;
  int          n_errors = 0, checks_done = 0;
  logic [11:0] rstIdx [10] = '{12'h0b8, 12'h0c1, 12'h0c5, 12'h0d0, 12'h0d1,
                               12'h0d5, 12'h0e0, 12'h0e5, 12'he10, 12'h3ff};
  logic [7:0]  clkOpt [4] = '{8'h00, 8'h20, 8'h40, 8'h01};
  logic [7:0]  p0OeExp [4] = '{8'hfb, 8'hf3, 8'he3, 8'hfa};

  gpb_top i_gpb_top (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port0In(p0In),
    .port0Out(p0Out), .port0Oe(p0Oe), .port0PullOn(p0Pull), .port1In(p1In),
    .port1Out(p1Out), .port1Oe(p1Oe), .port1PullOn(p1Pull), .port5In(p5In),
    .port5Out(p5Out), .port5Oe(p5Oe), .port5PullOn(p5Pull), .irCarrierIn(irCarrierIn),
    .extIntFlag(extIntFlag), .extIntRequest(extIntRequest));
  gpb_board_model i_gpb_board_model_p0 (.sys_clk(sys_clk), .pinOut(p0Out), .pinOe(p0Oe),
    .pinPull(p0Pull), .boardEn(b0En), .boardVal(b0Val), .pinLevel(p0In));
  gpb_board_model i_gpb_board_model_p1 (.sys_clk(sys_clk), .pinOut(p1Out), .pinOe(p1Oe),
    .pinPull(p1Pull), .boardEn(b1En), .boardVal(b1Val), .pinLevel(p1In));
  gpb_board_model i_gpb_board_model_p5 (.sys_clk(sys_clk), .pinOut(p5Out), .pinOe(p5Oe),
    .pinPull(p5Pull), .boardEn(b5En), .boardVal(b5Val), .pinLevel(p5In));

  // ****************************************************************
  // Clock, helpers and bus tasks
  // ****************************************************************
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  function automatic [31:0] xs(input [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Bounded wait for the ready edge
  task automatic waitRdy;
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      tally_and_finish;
    end
  endtask

  task automatic bus(input bit wr, input [11:0] idx, input [31:0] wd);
    hsel <= 1'b1;
    haddr <= {18'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    waitRdy;
    htrans <= 2'b00;
    hwdata <= wd;
    waitRdy;
    rdv = hrdata;
  endtask

  task automatic wr(input [11:0] idx, input [31:0] wd);
    bus(1'b1, idx, wd);
  endtask

  task automatic chkRd(input [11:0] idx, input [7:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rdv, {24'h0, exp}, "read");
  endtask

  task automatic settle;
    repeat (4) @(posedge sys_clk);
  endtask

  // Hang guard
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_errors++;
    tally_and_finish;
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    foreach (rstIdx[i]) chkRd(rstIdx[i], 8'h00);
    $display("test reset values done");
    repeat (6) begin
      rnd = xs(rnd);
      d = rnd[7:0];
      v = rnd[15:8];
      b1Val <= rnd[23:16];
      wr(12'h0c1, d);
      wr(12'h0d1, v);
      wr(12'h0c5, d);
      settle;
      chk(p1Oe, d, "p1 oe");
      chk(p1Out, v & d, "p1 out");
      chk(p5Oe, d & 8'h11, "p5 oe");
      chkRd(12'h0d1, (v & d) | (b1Val & ~d));
    end
    $display("test direction and data done");
    wr(12'h0c1, 8'h5a);
    wr(12'h0f8, 32'h181);
    wr(12'h0f9, 32'h118);
    chkRd(12'h0c1, 8'hc3);
    wr(12'h0f8, 32'h2ff);
    chkRd(12'h0c5, 8'h11);
    wr(12'h0b8, 8'h00);
    wr(12'h0f8, 32'h004);
    chkRd(12'h0b8, 8'h00);
    $display("test set and clear done");
    b0En <= 8'h04;
    b0Val <= 8'h00;
    wr(12'h0e0, 8'hff);
    wr(12'h0b8, 8'hff);
    settle;
    chk(p0Oe, 8'hfb, "p0 oe");
    chk(p0Pull, 8'h00, "p0 pull out");
    wr(12'h0b8, 8'h00);
    settle;
    chk(p0Pull, 8'hfb, "p0 pull in");
    chkRd(12'h0d0, 8'hfb);
    chkRd(12'h0e0, 8'h00);
    wr(12'h0f0, 8'h10);
    settle;
    chkRd(12'h0d0, 8'hff);
    wr(12'h0e0, 8'h00);
    settle;
    chk(p0Pull, 8'h00, "p0 pull off");
    b1En <= 8'h00;
    wr(12'h0c1, 8'h00);
    wr(12'he10, 8'hff);
    settle;
    chk(p1Pull, 8'hff, "p1 pull");
    $display("test pull-ups done");
    wr(12'h0b8, 8'hff);
    wr(12'h0d0, 8'hff);
    foreach (clkOpt[i]) begin
      wr(12'h0f0, clkOpt[i]);
      settle;
      chk(p0Oe, p0OeExp[i], "shared p0");
      chk(p0Out, p0OeExp[i], "shared p0 out");
    end
    irCarrierIn <= 1'b1;
    wr(12'h0c5, 8'h00);
    wr(12'h0f0, 8'h08);
    settle;
    chk({p5Oe, p5Out}, 16'h1010, "ir out");
    irCarrierIn <= 1'b0;
    settle;
    chk({p5Oe, p5Out}, 16'h1000, "ir low");
    $display("test shared pins done");
    wr(12'h0b8, 8'h00);
    b0En <= 8'hff;
    wr(12'h0f0, 8'h02);
    settle;
    b0Val <= 8'h01;
    settle;
    chk({extIntFlag, extIntRequest}, 2'b10, "rise flag");
    wr(12'h0f0, 8'h05);
    settle;
    chk({extIntFlag, extIntRequest}, 2'b11, "request");
    wr(12'h0f1, 8'h01);
    settle;
    chk(extIntFlag, 1'b0, "cleared");
    b0Val <= 8'h00;
    settle;
    chk({extIntFlag, extIntRequest}, 2'b11, "fall flag");
    wr(12'h0f0, 8'h06);
    wr(12'h0f1, 8'h01);
    settle;
    chk(extIntFlag, 1'b0, "both cleared");
    b0Val <= 8'h01;
    settle;
    chk({extIntFlag, extIntRequest}, 2'b10, "both rise");
    wr(12'h0f1, 8'h01);
    settle;
    b0Val <= 8'h00;
    settle;
    chk({extIntFlag, extIntRequest}, 2'b10, "both fall");
    $display("test external edge done");
    tally_and_finish;
  end
endmodule // gpb_top_tb
